// file: rtl/iscr_params.svh
// offsets, field positions and reset values of the security configuration registers
`ifndef ISCR_PARAMS_SVH
`define ISCR_PARAMS_SVH
`define ISCR_ADDR_W          6
`define ISCR_OFS_CTRL_MAIN   6'h19
`define ISCR_OFS_LEN_COUNTS  6'h1A
`define ISCR_CTRL_WMASK      16'h03FF
`define ISCR_LEN_WMASK       16'h7F7F
`define ISCR_CTRL_RESET      16'h03C4
`define ISCR_LEN_RESET       16'h0000
`define ISCR_B_GUARD         9
`define ISCR_B_FIRST_LEN     8
`define ISCR_B_SA_KEY        7
`define ISCR_B_TX_KEY        6
`define ISCR_B_RX_KEY        5
`define ISCR_F_M_HI          4
`define ISCR_F_M_LO          2
`define ISCR_F_MODE_HI       1
`define ISCR_F_MODE_LO       0
`define ISCR_F_TXL_HI        14
`define ISCR_F_TXL_LO        8
`define ISCR_F_RXL_HI        6
`define ISCR_F_RXL_LO        0
`define ISCR_TAG_OFFSET      5'h02
`define ISCR_LEN_HDR_OVH     8'h02
`endif

// file: rtl/iscr_pkg.sv
// types shared by the security configuration register bank
package iscr_pkg;
	typedef enum logic [1:0] {
		ISCR_MODE_OFF,
		ISCR_MODE_CBC_MAC,
		ISCR_MODE_CTR,
		ISCR_MODE_CCM
	} iscr_mode_t;
endpackage

// file: rtl/iscr_reg16.sv
// one 16-bit write-masked configuration register
`timescale 1ns/100ps
`default_nettype none
module iscr_reg16
	import iscr_pkg::*;
#(
	parameter logic [15:0] RESET_VAL = 16'h0000,
	parameter logic [15:0] WMASK     = 16'hFFFF
)
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rstn,
	// write side
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	// stored value
	output logic      [15:0] q
);
	logic [15:0] q_r;
	logic [15:0] q_nxt;
	// a reset value in a masked bit could never be written back
	if ((RESET_VAL & ~WMASK) != 16'h0000)
	begin : g_reset_in_mask
		$error("reset value sets a bit that writes cannot reach");
	end
	// reserved bits never store, so they always read as zero
	assign q_nxt = wr_en ? (wr_data & WMASK) : q_r;
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			q_r <= RESET_VAL;
		else
			q_r <= q_nxt;
	end
	assign q = q_r;
endmodule
`default_nettype wire

// file: rtl/iscr_top.sv
// in-line security configuration registers with decoded controls
`timescale 1ns/100ps
`default_nettype none
`include "iscr_params.svh"
// Operation
// - bit 9 enables receive buffer protection, resets to one
// - bit 8 set feeds a length byte before first data into CBC-MAC
// - first-byte choice applies only in plain CBC-MAC mode, never CCM
// - key selectors: stand-alone bit 7, transmit bit 6, receive bit 5
// - bits 4..2 give tag length as (M-2)/2, code 0 reserved, reset 1
// - bits 1..0 select off, CBC-MAC, CTR or CCM; reset off
// - CTR: transmit count is cleartext bytes before encryption
// - CBC-MAC: count is cleartext bytes before authentication
// - CCM: count is l(a), authenticated but not ciphered bytes
// - stand-alone operations ignore both length counts
// - receive count bits 6..0 mirror transmit meanings; both reset zero
module iscr_top
	import iscr_pkg::*;
(
	// clock and reset
	input  wire logic                    mclk,
	input  wire logic                    rstn,
	// register access from the serial interface
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	input  wire logic [`ISCR_ADDR_W-1:0] reg_addr,
	input  wire logic [15:0]             reg_wdata,
	output logic      [15:0]             reg_rdata,
	output logic                         reg_hit,
	// engine context
	input  wire logic                    standalone_active,
	input  wire logic                    dir_is_rx,
	input  wire logic [7:0]              packet_length,
	// decoded controls
	output logic                         rx_buffer_guard_en,
	output logic                         mac_length_byte_en,
	output logic [7:0]                   mac_length_byte,
	output logic                         active_key_choice,
	output iscr_mode_t                   inline_security_mode,
	output logic [4:0]                   auth_tag_bytes,
	output logic                         auth_tag_code_bad,
	output logic [6:0]                   clear_count,
	output logic [6:0]                   plain_count,
	output logic [6:0]                   auth_only_count
);
	logic [15:0] ctrl_q;
	logic [15:0] len_q;
	wire         sel_ctrl = (reg_addr == `ISCR_OFS_CTRL_MAIN);
	wire         sel_len  = (reg_addr == `ISCR_OFS_LEN_COUNTS);

	// reserved bits masked off; host obliged to write zeros there
	iscr_reg16 #(.RESET_VAL(`ISCR_CTRL_RESET), .WMASK(`ISCR_CTRL_WMASK)) u_ctrl (
		.mclk    (mclk),
		.rstn    (rstn),
		.wr_en   (reg_wr && sel_ctrl),
		.wr_data (reg_wdata),
		.q       (ctrl_q)
	);
	iscr_reg16 #(.RESET_VAL(`ISCR_LEN_RESET), .WMASK(`ISCR_LEN_WMASK)) u_len (
		.mclk    (mclk),
		.rstn    (rstn),
		.wr_en   (reg_wr && sel_len),
		.wr_data (reg_wdata),
		.q       (len_q)
	);

	// field decode
	wire        guard_w     = ctrl_q[`ISCR_B_GUARD];
	wire        first_len_w = ctrl_q[`ISCR_B_FIRST_LEN];
	wire        sa_key_w    = ctrl_q[`ISCR_B_SA_KEY];
	wire        tx_key_w    = ctrl_q[`ISCR_B_TX_KEY];
	wire        rx_key_w    = ctrl_q[`ISCR_B_RX_KEY];
	wire [2:0]  m_code_w    = ctrl_q[`ISCR_F_M_HI:`ISCR_F_M_LO];
	wire [1:0]  mode_bits_w = ctrl_q[`ISCR_F_MODE_HI:`ISCR_F_MODE_LO];
	iscr_mode_t mode_w;
	assign mode_w = iscr_mode_t'(mode_bits_w);
	wire [6:0]  txl_w       = len_q[`ISCR_F_TXL_HI:`ISCR_F_TXL_LO];
	wire [6:0]  rxl_w       = len_q[`ISCR_F_RXL_HI:`ISCR_F_RXL_LO];

	// key choice by operation kind
	wire        key_w = standalone_active ? sa_key_w : (dir_is_rx ? rx_key_w : tx_key_w);
	// tag length M = 2*code + 2
	wire [4:0]  tag_w = {1'b0, m_code_w, 1'b0} + `ISCR_TAG_OFFSET;
	wire        tag_bad_w = (m_code_w == 3'h0);

	// direction count, ignored entirely for stand-alone work
	wire [6:0]  dir_cnt_w = standalone_active ? 7'h00 : (dir_is_rx ? rxl_w : txl_w);
	wire        is_ctr_w  = (mode_w == ISCR_MODE_CTR);
	wire        is_cbc_w  = (mode_w == ISCR_MODE_CBC_MAC);
	wire        is_ccm_w  = (mode_w == ISCR_MODE_CCM);
	// the count means cleartext prefix for CTR and CBC-MAC, l(a) for CCM
	wire [6:0]  plain_w   = is_ctr_w ? dir_cnt_w : 7'h00;
	wire [6:0]  clear_w   = is_cbc_w ? dir_cnt_w : 7'h00;
	wire [6:0]  aonly_w   = is_ccm_w ? dir_cnt_w : 7'h00;

	// length byte only in plain CBC-MAC, CCM has its own header format
	wire        len_en_w  = first_len_w && is_cbc_w && !standalone_active;
	wire [7:0]  tx_len_w  = packet_length - {1'b0, txl_w} - `ISCR_LEN_HDR_OVH;
	wire [7:0]  len_byte_w = dir_is_rx ? {1'b0, rxl_w} : tx_len_w;

	wire        hit_w   = sel_ctrl || sel_len;
	wire [15:0] rdata_w = sel_ctrl ? ctrl_q : (sel_len ? len_q : 16'h0000);

	// outputs registered one cycle after their cause
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			reg_rdata            <= 16'h0000;
			reg_hit              <= 1'b0;
			rx_buffer_guard_en   <= 1'b1;
			mac_length_byte_en   <= 1'b0;
			mac_length_byte      <= 8'h00;
			active_key_choice    <= 1'b0;
			inline_security_mode <= ISCR_MODE_OFF;
			auth_tag_bytes       <= 5'h00;
			auth_tag_code_bad    <= 1'b0;
			clear_count          <= 7'h00;
			plain_count          <= 7'h00;
			auth_only_count      <= 7'h00;
		end
		else
		begin
			reg_rdata            <= reg_rd ? rdata_w : 16'h0000;
			reg_hit              <= (reg_rd || reg_wr) && hit_w;
			rx_buffer_guard_en   <= guard_w;
			mac_length_byte_en   <= len_en_w;
			mac_length_byte      <= len_en_w ? len_byte_w : 8'h00;
			active_key_choice    <= key_w;
			inline_security_mode <= mode_w;
			auth_tag_bytes       <= tag_w;
			auth_tag_code_bad    <= tag_bad_w;
			clear_count          <= clear_w;
			plain_count          <= plain_w;
			auth_only_count      <= aonly_w;
		end
	end

	// checks
	sequence s_ctrl_write;
		reg_wr && sel_ctrl;
	endsequence
	sequence s_decode_settled;
		##2 1'b1;
	endsequence
	sequence s_len_write;
		reg_wr && sel_len;
	endsequence
	sequence s_ctrl_read;
		reg_rd && sel_ctrl;
	endsequence
	AST_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
		(ctrl_q[15:10] == 6'h00) && (len_q[15] == 1'b0) && (len_q[7] == 1'b0))
		else $error("reserved bit stored");
	AST_GUARD_FOLLOWS: assert property (@(posedge mclk) disable iff (!rstn)
		s_ctrl_write |-> s_decode_settled ##0 (rx_buffer_guard_en == $past(reg_wdata[9], 2)))
		else $error("guard enable not taken from write");
	AST_LEN_BYTE_CBC_ONLY: assert property (@(posedge mclk) disable iff (!rstn)
		mac_length_byte_en |-> (inline_security_mode == ISCR_MODE_CBC_MAC))
		else $error("length byte outside CBC-MAC");
	AST_LEN_BYTE_VALUE: assert property (@(posedge mclk) disable iff (!rstn)
		len_en_w && !dir_is_rx |=> (mac_length_byte == $past(packet_length) - {1'b0, $past(txl_w)} - 8'h02))
		else $error("tx length byte wrong");
	AST_KEY_SELECT: assert property (@(posedge mclk) disable iff (!rstn)
		standalone_active |=> (active_key_choice == $past(ctrl_q[7])))
		else $error("stand-alone key wrong");
	AST_TAG_LENGTH: assert property (@(posedge mclk) disable iff (!rstn)
		1'b1 |=> !auth_tag_bytes[0] && (auth_tag_bytes[4:1] == {1'b0, $past(m_code_w)} + 4'h1))
		else $error("tag length wrong");
	AST_MODE_WRITE: assert property (@(posedge mclk) disable iff (!rstn)
		s_ctrl_write |-> ##2 (inline_security_mode == iscr_mode_t'($past(reg_wdata[1:0], 2))))
		else $error("mode not taken from write");
	AST_CTR_COUNT: assert property (@(posedge mclk) disable iff (!rstn)
		is_ctr_w && !standalone_active && !dir_is_rx |=> (plain_count == $past(txl_w)))
		else $error("CTR count wrong");
	AST_CBC_COUNT: assert property (@(posedge mclk) disable iff (!rstn)
		is_cbc_w && !standalone_active && dir_is_rx |=> (clear_count == $past(rxl_w)))
		else $error("CBC-MAC count wrong");
	AST_CCM_COUNT: assert property (@(posedge mclk) disable iff (!rstn)
		is_ccm_w && !standalone_active |=> (auth_only_count == $past(dir_cnt_w)) && (clear_count == 7'h00))
		else $error("CCM count wrong");
	AST_STANDALONE_IGNORES: assert property (@(posedge mclk) disable iff (!rstn)
		standalone_active |=> (clear_count == 7'h00) && (plain_count == 7'h00) && (auth_only_count == 7'h00))
		else $error("stand-alone used a count");
	AST_RX_COUNT_STORED: assert property (@(posedge mclk) disable iff (!rstn)
		reg_wr && sel_len |=> (len_q[6:0] == $past(reg_wdata[6:0])))
		else $error("receive count not stored");
	// each direction checked on its own for keys and for CTR and CBC-MAC counts, so a swapped select shows up; CCM uses dir_cnt_w
	AST_RX_KEY: assert property (@(posedge mclk) disable iff (!rstn)
		!standalone_active && dir_is_rx |=> (active_key_choice == $past(ctrl_q[`ISCR_B_RX_KEY])))
		else $error("receive key wrong");
	AST_TX_KEY: assert property (@(posedge mclk) disable iff (!rstn)
		!standalone_active && !dir_is_rx |=> (active_key_choice == $past(ctrl_q[`ISCR_B_TX_KEY])))
		else $error("transmit key wrong");
	AST_TAG_CODE_FLAG: assert property (@(posedge mclk) disable iff (!rstn)
		auth_tag_code_bad == (auth_tag_bytes == 5'h02))
		else $error("reserved tag code flag wrong");
	AST_RX_LEN_BYTE: assert property (@(posedge mclk) disable iff (!rstn)
		len_en_w && dir_is_rx |=> (mac_length_byte == {1'b0, $past(rxl_w)}))
		else $error("rx length byte wrong");
	AST_HEAD_OFF: assert property (@(posedge mclk) disable iff (!rstn)
		!first_len_w |=> !mac_length_byte_en && (mac_length_byte == 8'h00))
		else $error("length byte while first byte is data");
	AST_CCM_NO_HEAD: assert property (@(posedge mclk) disable iff (!rstn)
		is_ccm_w && first_len_w |=> !mac_length_byte_en)
		else $error("length byte in CCM");
	AST_CTR_RX_COUNT: assert property (@(posedge mclk) disable iff (!rstn)
		is_ctr_w && !standalone_active && dir_is_rx |=>
			(plain_count == $past(rxl_w)) && (auth_only_count == 7'h00))
		else $error("CTR receive count wrong");
	AST_CBC_TX_COUNT: assert property (@(posedge mclk) disable iff (!rstn)
		is_cbc_w && !standalone_active && !dir_is_rx |=>
			(clear_count == $past(txl_w)) && (plain_count == 7'h00))
		else $error("CBC-MAC transmit count wrong");
	AST_OFF_IDLE: assert property (@(posedge mclk) disable iff (!rstn)
		(mode_w == ISCR_MODE_OFF) |=> (clear_count == 7'h00) && (plain_count == 7'h00) && !mac_length_byte_en)
		else $error("security off but controls active");
	AST_TX_COUNT_STORED: assert property (@(posedge mclk) disable iff (!rstn)
		s_len_write |=> (len_q[`ISCR_F_TXL_HI:`ISCR_F_TXL_LO] == $past(reg_wdata[`ISCR_F_TXL_HI:`ISCR_F_TXL_LO])))
		else $error("transmit count not stored");
	AST_READ_CTRL: assert property (@(posedge mclk) disable iff (!rstn)
		s_ctrl_read |=> reg_hit && (reg_rdata == $past(ctrl_q)) && (reg_rdata[15:10] == 6'h00))
		else $error("control read wrong");
endmodule
`default_nettype wire

// file: bench/iscr_host.sv
// host-side model that drives register accesses
`timescale 1ns/100ps
`default_nettype none
module iscr_host
(
	// clock
	input  wire logic        mclk,
	// register strobes
	output logic             reg_wr,
	output logic             reg_rd,
	output logic [5:0]       reg_addr,
	output logic [15:0]      reg_wdata
);
	initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
	task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d, input logic raw);
		@(negedge mclk);
		reg_wr = w;
		reg_rd = ~w;
		reg_addr = a;
		// reserved bits kept low unless a probe asks for them
		reg_wdata = raw ? d : d & (a == 6'h19 ? 16'h03FF : 16'h7F7F);
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		// released lines must not keep looking valid
		reg_addr = ~a;
		reg_wdata = ~reg_wdata;
	endtask
endmodule
`default_nettype wire

// file: bench/iscr_top_tb.sv
// self-checking bench for the security configuration registers
`timescale 1ns/100ps
`default_nettype none
module iscr_top_tb
	import iscr_pkg::*;
();
	logic        mclk = 1'b0, rstn = 1'b0, sa = 1'b0, rx = 1'b0, acc_q = 1'b0, le;
	logic        wr, rd, hit, guard, len_en, key, bad;
	logic [5:0]  addr;
	logic [7:0]  plen = 8'h00, lbyte;
	logic [6:0]  c_clr, c_pl, c_ao, n;
	logic [4:0]  tagb;
	logic [15:0] wd, rdat, ctl = 16'h03C4, len = 16'h0000;
	logic [1:0]  m;
	iscr_mode_t  mode;
	logic [31:0] exp_q[$];
	int          num_errors = 0, n_checks = 0;
	always #5 mclk = ~mclk;
	iscr_top i_dut
	(
		.mclk(mclk), .rstn(rstn), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(rdat),
		.reg_hit(hit), .standalone_active(sa), .dir_is_rx(rx), .packet_length(plen), .rx_buffer_guard_en(guard),
		.mac_length_byte_en(len_en), .mac_length_byte(lbyte), .active_key_choice(key), .inline_security_mode(mode),
		.auth_tag_bytes(tagb), .auth_tag_code_bad(bad), .clear_count(c_clr), .plain_count(c_pl), .auth_only_count(c_ao)
	);
	iscr_host i_host (.mclk(mclk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd));
	// every access, write or read, leaves one note and one answer a cycle later
	always @(posedge mclk) acc_q <= rd || wr;
	always @(negedge mclk)
		if (acc_q)
			chk("access", exp_q.size() ? exp_q.pop_front() : 32'hFFFFFFFF, {hit, rdat});
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d, input logic raw,
		input logic [31:0] e);
		exp_q.push_back(e);
		i_host.acc(w, a, d, raw);
	endtask
	// decoded outputs settle two cycles after a write, one after a context change
	task automatic dec();
		m = ctl[1:0];
		n = sa ? 7'h00 : rx ? len[6:0] : len[14:8];
		le = ctl[8] && m == 2'h1 && !sa;
		repeat (2) @(negedge mclk);
		chk("ctrl", {m, ctl[9], sa ? ctl[7] : rx ? ctl[5] : ctl[6], ctl[4:2] == 3'h0,
			{1'b0, ctl[4:2], 1'b0} + 5'h02}, {mode, guard, key, bad, tagb});
		chk("cnt", {m == 2'h1 ? n : 7'h00, m == 2'h2 ? n : 7'h00, m == 2'h3 ? n : 7'h00},
			{c_clr, c_pl, c_ao});
		chk("lb", {le, le ? (rx ? {1'b0, len[6:0]} : plen - {1'b0, len[14:8]} - 8'h02) : 8'h00},
			{len_en, lbyte});
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		void'($urandom(32'h8d18));
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		rstn = 1'b1;
		xfer(1'b0, 6'h19, 16'h0000, 1'b0, 32'h103C4);
		xfer(1'b0, 6'h1A, 16'h0000, 1'b0, 32'h10000);
		dec();
		$display("reset values test done");
		xfer(1'b1, 6'h19, 16'hFFFF, 1'b1, 32'h10000);
		xfer(1'b0, 6'h19, 16'h0000, 1'b0, 32'h103FF);
		xfer(1'b1, 6'h1A, 16'hFFFF, 1'b1, 32'h10000);
		xfer(1'b0, 6'h1A, 16'h0000, 1'b0, 32'h17F7F);
		xfer(1'b1, 6'h1B, 16'hFFFF, 1'b1, 32'h00000);
		xfer(1'b0, 6'h1B, 16'h0000, 1'b0, 32'h00000);
		$display("access test done");
		for (int i = 0; i < 128; i++)
		begin
			ctl = 16'($urandom) & 16'h03FF;
			ctl[4:0] = i[4:0];
			ctl[8] = i[2] ^ i[3];
			len = 16'($urandom) & 16'h7F7F;
			{rx, sa} = i[6:5];
			plen = 8'($urandom);
			xfer(1'b1, 6'h19, ctl, 1'b0, 32'h10000);
			xfer(1'b1, 6'h1A, len, 1'b0, 32'h10000);
			xfer(1'b0, 6'h1A, 16'h0000, 1'b0, {16'h0001, len});
			dec();
		end
		$display("mode and count test done");
		close_out();
	end
endmodule
`default_nettype wire
